// *** plt_pkg.sv ***
// constants and types shared by the palette host access block
// assumes a single controller clock and byte-wide host port accesses
package plt_pkg;

  // host port addresses, compared against the full 16-bit port address
  localparam logic [15:0] PLT_ADDR_MASK = 16'h03C6;
  localparam logic [15:0] PLT_ADDR_RIDX = 16'h03C7;
  localparam logic [15:0] PLT_ADDR_WIDX = 16'h03C8;
  localparam logic [15:0] PLT_ADDR_DATA = 16'h03C9;

  // lookup table geometry
  localparam int PLT_ENTRIES = 256;
  localparam int PLT_IDX_W = 8;
  localparam int PLT_COMP_W = 6;
  localparam int PLT_ENTRY_W = 18;

  // field positions inside an 18-bit entry
  localparam int PLT_RED_LSB = 12;
  localparam int PLT_GRN_LSB = 6;
  localparam int PLT_BLU_LSB = 0;

  // status bit values
  localparam logic [1:0] PLT_STAT_READ = 2'h0;
  localparam logic [1:0] PLT_STAT_WRITE = 2'h3;

  // values after reset, and the index increment step
  localparam logic [7:0] PLT_RST_MASK = 8'hFF;
  localparam logic [7:0] PLT_RST_IDX = 8'h00;
  localparam logic [17:0] PLT_RST_HOLD = 18'h00000;
  localparam logic [7:0] PLT_IDX_STEP = 8'h01;

  // position inside the three-access component sequence
  typedef enum logic [2:0] {
    PLT_PH_RED = 3'b001,
    PLT_PH_GRN = 3'b010,
    PLT_PH_BLU = 3'b100
  } plt_phase_t;

endpackage

// *** plt_lut.sv ***
// 256 x 18 color lookup table held in flip-flops
// assumes one write port and two combinational read ports on one clock
`timescale 1ns/1ps
`default_nettype none

module plt_lut (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [plt_pkg::PLT_IDX_W-1:0] waddr_i,
  input wire logic [plt_pkg::PLT_ENTRY_W-1:0] wdata_i,
  input wire logic [plt_pkg::PLT_IDX_W-1:0] raddr_a_i,
  output logic [plt_pkg::PLT_ENTRY_W-1:0] rdata_a_o,
  input wire logic [plt_pkg::PLT_IDX_W-1:0] raddr_b_i,
  output logic [plt_pkg::PLT_ENTRY_W-1:0] rdata_b_o
);
  import plt_pkg::*;

  typedef struct packed {
    logic [PLT_ENTRIES-1:0][PLT_ENTRY_W-1:0] mem;
  } plt_lut_state_t;

  plt_lut_state_t st_ff;
  plt_lut_state_t nxt_st;

  // contents are not reset; software loads the table before use
  always_comb begin
    nxt_st = st_ff;
    if (we_i) begin
      nxt_st.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end

  assign rdata_a_o = st_ff.mem[raddr_a_i];
  assign rdata_b_o = st_ff.mem[raddr_b_i];

endmodule

`default_nettype wire

// *** plt_host_ports.sv ***
// palette host access ports: mask, status, read/write index, data port
// assumes host strobes are synchronous to sys_clk_i, one cycle per access
//
// Contract
// - refresh index is pixel mask ANDed with attribute color code
// - mask never alters host palette accesses; host uses unmasked index
// - mask readable and writable any time without touching table
// - mask has no meaningful reset value; software programs it
// - read at dual port gives status; write loads read index
// - status bits 1:0 are 00 after read-index write, 11 after write-index
// - read-index write fetches addressed entry into 18-bit holding register
// - each data read gives one 6-bit component, upper two bits zero
// - components read out red, green, blue; host reads three per entry
// - after third data read the read index increments by one
// - three data writes concatenate low six bits into 18-bit holding value
// - data writes taken as red, green, blue after write-index set
// - third component write stores holding value at write index
// - after storing, write index increments by one
// - data port moves 6-bit components both ways to 18-bit entries
// - write index readable and writable at its own port
// - table holds 256 entries of three 6-bit components
`timescale 1ns/1ps
`default_nettype none

module plt_host_ports (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  input wire logic [plt_pkg::PLT_IDX_W-1:0] pix_color_i,
  input wire logic pix_valid_i,
  output logic [plt_pkg::PLT_COMP_W-1:0] pix_red_o,
  output logic [plt_pkg::PLT_COMP_W-1:0] pix_grn_o,
  output logic [plt_pkg::PLT_COMP_W-1:0] pix_blu_o,
  output logic pix_valid_o
);
  import plt_pkg::*;

  typedef struct packed {
    logic [PLT_IDX_W-1:0] mask;
    logic [PLT_IDX_W-1:0] rd_idx;
    logic [PLT_IDX_W-1:0] wr_idx;
    logic wr_mode;
    plt_phase_t phase;
    logic [PLT_ENTRY_W-1:0] hold;
    logic [7:0] rdata;
    logic rvalid;
    logic [PLT_COMP_W-1:0] pix_red;
    logic [PLT_COMP_W-1:0] pix_grn;
    logic [PLT_COMP_W-1:0] pix_blu;
    logic pix_valid;
  } plt_state_t;

  localparam plt_state_t PLT_RST_STATE = '{
    mask: PLT_RST_MASK,
    rd_idx: PLT_RST_IDX,
    wr_idx: PLT_RST_IDX,
    wr_mode: 1'b0,
    phase: PLT_PH_RED,
    hold: PLT_RST_HOLD,
    rdata: 8'h00,
    rvalid: 1'b0,
    pix_red: 6'h00,
    pix_grn: 6'h00,
    pix_blu: 6'h00,
    pix_valid: 1'b0
  };

  plt_state_t st_ff;
  plt_state_t nxt_st;

  logic sel_mask;
  logic sel_ridx;
  logic sel_widx;
  logic sel_data;

  logic lut_we;
  logic [PLT_IDX_W-1:0] lut_waddr;
  logic [PLT_ENTRY_W-1:0] lut_wdata;
  logic [PLT_IDX_W-1:0] refresh_idx;
  logic [PLT_ENTRY_W-1:0] refresh_entry;
  logic [PLT_IDX_W-1:0] fetch_addr;
  logic [PLT_ENTRY_W-1:0] fetch_entry;
  logic fetch;

  assign sel_mask = (io_addr_i == PLT_ADDR_MASK);
  assign sel_ridx = (io_addr_i == PLT_ADDR_RIDX);
  assign sel_widx = (io_addr_i == PLT_ADDR_WIDX);
  assign sel_data = (io_addr_i == PLT_ADDR_DATA);

  // refresh path only; host index and data ports never see the mask
  assign refresh_idx = pix_color_i & st_ff.mask;

  // one lane per color channel: lane 0 blue, lane 1 green, lane 2 red
  // red sits in the top six bits of an entry
  logic [2:0][PLT_COMP_W-1:0] refresh_comp;

  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    localparam int LANE_LSB = PLT_BLU_LSB + ch * PLT_COMP_W;
    assign refresh_comp[ch] = refresh_entry[LANE_LSB +: PLT_COMP_W];
  end

  // picks one component of an entry into the low bits
  function automatic logic [7:0] comp_byte(
    input logic [PLT_ENTRY_W-1:0] entry,
    input plt_phase_t ph
  );
    logic [7:0] b;
    b = 8'h00;
    case (ph)
      PLT_PH_RED: b = {2'b00, entry[PLT_RED_LSB +: PLT_COMP_W]};
      PLT_PH_GRN: b = {2'b00, entry[PLT_GRN_LSB +: PLT_COMP_W]};
      PLT_PH_BLU: b = {2'b00, entry[PLT_BLU_LSB +: PLT_COMP_W]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // 256 x 18 table
  plt_lut u_lut (
    .sys_clk_i(sys_clk_i),
    .we_i(lut_we),
    .waddr_i(lut_waddr),
    .wdata_i(lut_wdata),
    .raddr_a_i(refresh_idx),
    .rdata_a_o(refresh_entry),
    .raddr_b_i(fetch_addr),
    .rdata_b_o(fetch_entry)
  );

  always_comb begin
    nxt_st = st_ff;
    lut_we = 1'b0;
    lut_waddr = st_ff.wr_idx;
    lut_wdata = st_ff.hold;
    fetch = 1'b0;
    fetch_addr = st_ff.rd_idx;
    nxt_st.rvalid = 1'b0;
    nxt_st.rdata = 8'h00;

    // a write and a read in one cycle: the write is served
    if (io_wr_i) begin
      if (sel_mask) begin
        // plain store, the table is left alone
        nxt_st.mask = io_wdata_i;
      end else if (sel_ridx) begin
        // write side of the dual port loads the read index
        nxt_st.rd_idx = io_wdata_i;
        nxt_st.wr_mode = 1'b0;
        nxt_st.phase = PLT_PH_RED;
        fetch = 1'b1;
        fetch_addr = io_wdata_i;
      end else if (sel_widx) begin
        nxt_st.wr_idx = io_wdata_i;
        nxt_st.wr_mode = 1'b1;
        nxt_st.phase = PLT_PH_RED;
      end else if (sel_data) begin
        case (st_ff.phase)
          PLT_PH_RED: begin
            nxt_st.hold[PLT_RED_LSB +: PLT_COMP_W] =
              io_wdata_i[PLT_COMP_W-1:0];
            nxt_st.phase = PLT_PH_GRN;
          end
          PLT_PH_GRN: begin
            nxt_st.hold[PLT_GRN_LSB +: PLT_COMP_W] =
              io_wdata_i[PLT_COMP_W-1:0];
            nxt_st.phase = PLT_PH_BLU;
          end
          PLT_PH_BLU: begin
            nxt_st.hold[PLT_BLU_LSB +: PLT_COMP_W] =
              io_wdata_i[PLT_COMP_W-1:0];
            // blue goes straight to the table to save a cycle
            lut_we = 1'b1;
            lut_wdata = {st_ff.hold[PLT_ENTRY_W-1:PLT_GRN_LSB],
                         io_wdata_i[PLT_COMP_W-1:0]};
            nxt_st.wr_idx = st_ff.wr_idx + PLT_IDX_STEP;
            nxt_st.phase = PLT_PH_RED;
          end
          default: begin
            nxt_st.phase = PLT_PH_RED;
          end
        endcase
      end
    end else if (io_rd_i) begin
      if (sel_mask) begin
        nxt_st.rvalid = 1'b1;
        nxt_st.rdata = st_ff.mask;
      end else if (sel_ridx) begin
        nxt_st.rvalid = 1'b1;
        // read side of the dual port is status only
        nxt_st.rdata = {6'h00,
                        st_ff.wr_mode ? PLT_STAT_WRITE : PLT_STAT_READ};
      end else if (sel_widx) begin
        nxt_st.rvalid = 1'b1;
        nxt_st.rdata = st_ff.wr_idx;
      end else if (sel_data) begin
        nxt_st.rvalid = 1'b1;
        nxt_st.rdata = comp_byte(st_ff.hold, st_ff.phase);
        case (st_ff.phase)
          PLT_PH_RED: nxt_st.phase = PLT_PH_GRN;
          PLT_PH_GRN: nxt_st.phase = PLT_PH_BLU;
          PLT_PH_BLU: begin
            nxt_st.rd_idx = st_ff.rd_idx + PLT_IDX_STEP;
            nxt_st.phase = PLT_PH_RED;
            // reload from the next entry now so back-to-back reads work
            fetch = 1'b1;
            fetch_addr = st_ff.rd_idx + PLT_IDX_STEP;
          end
          default: nxt_st.phase = PLT_PH_RED;
        endcase
      end
    end

    if (fetch) begin
      nxt_st.hold = fetch_entry;
    end

    // one cycle refresh latency through the table
    nxt_st.pix_red = refresh_comp[2];
    nxt_st.pix_grn = refresh_comp[1];
    nxt_st.pix_blu = refresh_comp[0];
    nxt_st.pix_valid = pix_valid_i;
  end

  // mask gets a reset value only to keep simulation clean
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_ff <= PLT_RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io_rdata_o = st_ff.rdata;
  assign io_rvalid_o = st_ff.rvalid;
  assign pix_red_o = st_ff.pix_red;
  assign pix_grn_o = st_ff.pix_grn;
  assign pix_blu_o = st_ff.pix_blu;
  assign pix_valid_o = st_ff.pix_valid;

endmodule

`default_nettype wire

// *** plt_host_props.sv ***
// assertion checker for the palette host ports, bound to plt_host_ports
// assumes strobes and pixel inputs are synchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module plt_host_props
  import plt_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  input wire logic [7:0] pix_color_i,
  input wire logic pix_valid_i,
  input wire logic [5:0] pix_red_o,
  input wire logic [5:0] pix_grn_o,
  input wire logic [5:0] pix_blu_o,
  input wire logic pix_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] msk_ff, wi_ff;
  logic [1:0] ph_ff;
  logic st_ff;
  // write wins over a read in the same cycle
  wire rdk = io_rd_i & ~io_wr_i;
  wire map = io_addr_i >= PLT_ADDR_MASK && io_addr_i <= PLT_ADDR_DATA;
  wire w7 = io_wr_i && io_addr_i == PLT_ADDR_RIDX;
  wire w8 = io_wr_i && io_addr_i == PLT_ADDR_WIDX;
  wire dac = (io_wr_i | rdk) && io_addr_i == PLT_ADDR_DATA;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      msk_ff <= PLT_RST_MASK;
      wi_ff <= PLT_RST_IDX;
      ph_ff <= 2'h0;
      st_ff <= 1'b0;
    end else begin
      if (io_wr_i && io_addr_i == PLT_ADDR_MASK) msk_ff <= io_wdata_i;
      if (w7 | w8) ph_ff <= 2'h0;
      else if (dac) ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
      if (w8) wi_ff <= io_wdata_i;
      else if (dac && io_wr_i && ph_ff == 2'h2) wi_ff <= wi_ff + 8'h01;
      if (w7 | w8) st_ff <= w8;
    end
  end
  rvalid_map_a: assert property (rdk && map |=> io_rvalid_o)
    else $error("no read answer");
  rvalid_none_a: assert property (!(rdk && map)
    |=> !io_rvalid_o) else $error("spurious read answer");
  rdata_idle_a: assert property (!io_rvalid_o
    |-> io_rdata_o == 8'h00) else $error("read data not zero");
  data_upper_a: assert property (rdk && io_addr_i == PLT_ADDR_DATA
    |=> io_rdata_o[7:6] == 2'h0) else $error("upper data bits set");
  status_bits_a: assert property (rdk &&
    io_addr_i == PLT_ADDR_RIDX |=> io_rdata_o[1:0] == {2{st_ff}})
    else $error("status wrong");
  mask_read_a: assert property (rdk && io_addr_i == PLT_ADDR_MASK
    |=> io_rdata_o == msk_ff) else $error("mask readback wrong");
  widx_read_a: assert property (rdk && io_addr_i == PLT_ADDR_WIDX
    |=> io_rdata_o == wi_ff) else $error("write index wrong");
  pix_valid_a: assert property (1'b1 |=>
    pix_valid_o == $past(pix_valid_i)) else $error("pixel valid delay wrong");
  cover property (dac && rdk ##3 dac && rdk ##3 dac && rdk);
  cover property (w8 ##[1:20] dac);
  cover property (rdk && io_addr_i == PLT_ADDR_RIDX);
endmodule
bind plt_host_ports plt_host_props u_props (.sys_clk_i, .nrst_i, .io_addr_i,
  .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .pix_color_i,
  .pix_valid_i, .pix_red_o, .pix_grn_o, .pix_blu_o, .pix_valid_o);
`default_nettype wire

// *** plt_host_model.sv ***
// host processor model issuing byte port reads and writes
// assumes answers come one cycle after the accepting edge
`timescale 1ns/1ps
`default_nettype none
module plt_host_model (
  input wire logic sys_clk_i,
  output logic [15:0] io_addr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i
);
  initial begin
    io_addr_o = 16'h0000;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // callers start each run of data accesses at red, right after an index write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    io_wr_o <= 1'b0;
    // released lines show the inverse so stale values never match
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    io_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    io_rd_o <= 1'b0;
    io_addr_o <= ~a;
    @(posedge sys_clk_i);
    d = io_rdata_i;
    v = io_rvalid_i;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the palette host ports
// assumes plt_host_model drives the host side of the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  import plt_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] pix_color_i = 8'h00;
  logic pix_valid_i = 1'b0;
  wire logic [15:0] io_addr;
  wire logic io_rd, io_wr, io_rvalid, pvo;
  wire logic [7:0] io_wdata, io_rdata;
  wire logic [5:0] red, grn, blu;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] d;
  logic v;
  always #12.5 sys_clk_i = ~sys_clk_i;
  plt_host_model host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr),
    .io_rd_o(io_rd), .io_wr_o(io_wr), .io_wdata_o(io_wdata),
    .io_rdata_i(io_rdata), .io_rvalid_i(io_rvalid));
  plt_host_ports dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid),
    .pix_color_i(pix_color_i), .pix_valid_i(pix_valid_i), .pix_red_o(red),
    .pix_grn_o(grn), .pix_blu_o(blu), .pix_valid_o(pvo));
  function automatic logic [5:0] comp(int e, int c);
    return 6'(e * 3 + c + 7);
  endfunction
  task automatic print_verdict;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    host.wr(PLT_ADDR_MASK, 8'hA5);
    host.rd(PLT_ADDR_MASK, d, v);
    `CHK(d, 8'hA5)
    // entries FE, FF and 00: the index must wrap; upper write bits set
    host.wr(PLT_ADDR_WIDX, 8'hFE);
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 3; k++)
        host.wr(PLT_ADDR_DATA, {2'h3, comp(i, k)});
    host.rd(PLT_ADDR_WIDX, d, v);
    `CHK(d, 8'h01)
    host.rd(PLT_ADDR_RIDX, d, v);
    `CHK(d[1:0], PLT_STAT_WRITE)
    host.wr(PLT_ADDR_MASK, 8'hFE);
    pix_color_i <= 8'hFF;
    pix_valid_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    `CHK({pvo, red, grn, blu},
      {1'b1, comp(0, 0), comp(0, 1), comp(0, 2)})
    // mask FE stays set; host reads of entry FF must ignore it
    host.wr(PLT_ADDR_RIDX, 8'hFE);
    host.rd(PLT_ADDR_RIDX, d, v);
    `CHK(d[1:0], PLT_STAT_READ)
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 3; k++) begin
        host.rd(PLT_ADDR_DATA, d, v);
        `CHK({v, d}, {1'b1, 2'h0, comp(i, k)})
      end
    host.wr(PLT_ADDR_RIDX, 8'h00);
    host.rd(PLT_ADDR_DATA, d, v);
    host.wr(PLT_ADDR_RIDX, 8'h00);
    host.rd(PLT_ADDR_DATA, d, v);
    `CHK(d, {2'h0, comp(2, 0)})
    host.rd(16'h03CA, d, v);
    `CHK({v, d}, 9'h000)
    print_verdict();
  end
endmodule
`default_nettype wire
